// *** rtl/card_reader_pkg.sv ***
// constants and types shared by the card column reader control
package card_reader_pkg;

  // ---------------------------------------------------------------
  // bus identity and widths
  // ---------------------------------------------------------------
  localparam logic [6:0] DEV_NUM = 7'h4C;
  localparam int WORD_W = 36;
  localparam int STAT_W = 18;
  localparam int COL_W = 12;
  localparam int CHAR_W = 6;
  localparam int PIA_W = 3;

  // ---------------------------------------------------------------
  // control and status field positions (index in the low halfword)
  // ---------------------------------------------------------------
  localparam int POS_NOT_READY = 11;
  localparam int POS_ERROR = 10;
  localparam int POS_EOF = 9;
  localparam int POS_EOC = 8;
  localparam int POS_MISSED = 7;
  localparam int POS_ALL = 6;
  localparam int POS_MODE = 5;
  localparam int POS_BUSY = 4;
  localparam int POS_DONE = 3;
  localparam int POS_PIA = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [PIA_W-1:0] PIA_RESET = 3'h0;
  localparam logic [WORD_W-1:0] WORD_RESET = 36'h0;
  localparam logic FLAG_RESET = 1'b0;

  // ---------------------------------------------------------------
  // card geometry and modes
  // ---------------------------------------------------------------
  localparam logic [6:0] COLS_PER_CARD = 7'h50;
  localparam logic [2:0] CHARS_PER_WORD = 3'h6;
  localparam logic [2:0] COLS_PER_BIN_WORD = 3'h3;
  localparam logic MODE_CHAR = 1'b0;
  localparam logic MODE_BIN = 1'b1;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int REREAD_WIN_NS = 2000000;
  localparam int REREAD_WIN_CYC = REREAD_WIN_NS / CLK_PERIOD_NS;
  localparam int TIMER_W = 15;

  // ---------------------------------------------------------------
  // character codes
  // ---------------------------------------------------------------
  localparam logic [5:0] CODE_BLANK = 6'h10;
  localparam logic [5:0] CODE_ILLEGAL = 6'h00;
  localparam logic [1:0] ZONE_12 = 2'h3;
  localparam logic [1:0] ZONE_11 = 2'h2;
  localparam logic [1:0] ZONE_0 = 2'h1;
  localparam logic [1:0] ZONE_NONE = 2'h0;
  localparam logic [3:0] DIGIT_ZERO = 4'hA;
  localparam logic [3:0] DIGIT_EIGHT = 4'h8;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_READ = 1'b1
  } rd_state_t;

endpackage

// *** rtl/col_xlate_if.sv ***
// column-to-character translation signals
`timescale 1ns/1ps
`default_nettype none
interface col_xlate_if;
  logic [11:0] column;
  logic [5:0] code;
  modport user (output column, input code);
  modport xlate (input column, output code);
endinterface
`default_nettype wire

// *** rtl/col_translator.sv ***
// translates a 12-row card column into a 6-bit character code
`timescale 1ns/1ps
`default_nettype none
module col_translator
  import card_reader_pkg::*;
(
  col_xlate_if.xlate xl
);

  // ---------------------------------------------------------------
  // rows: column[11]=12, [10]=11, [9]=0, [8..0]=1..9
  // ---------------------------------------------------------------
  logic [2:0] zones;
  logic has8;
  logic [3:0] n_cnt;
  logic [3:0] n_val;
  logic [1:0] zc;

  always_comb begin
    zones = xl.column[11:9];
    has8 = xl.column[1];
    n_cnt = 4'h0;
    n_val = 4'h0;
    for (int k = 1; k <= 9; k++) begin
      if (k != 8 && xl.column[9 - k]) begin
        n_cnt = n_cnt + 4'h1;
        n_val = 4'(k);
      end
    end
    unique case (zones)
      3'b100: zc = ZONE_12;
      3'b010: zc = ZONE_11;
      3'b001: zc = ZONE_0;
      default: zc = ZONE_NONE;
    endcase
    xl.code = CODE_ILLEGAL;
    if (xl.column[8:0] == 9'h000) begin
      unique case (zones)
        3'b000: xl.code = CODE_BLANK;
        3'b100: xl.code = {ZONE_12, 4'h0};
        3'b010: xl.code = {ZONE_11, 4'h0};
        3'b001: xl.code = {ZONE_NONE, DIGIT_ZERO};
        3'b101: xl.code = {ZONE_12, DIGIT_ZERO};
        3'b011: xl.code = {ZONE_11, DIGIT_ZERO};
        default: xl.code = CODE_ILLEGAL;
      endcase
    end else if (zones == 3'b000 || zc != ZONE_NONE) begin
      // fixed punch-to-code table
      if (!has8 && n_cnt == 4'h1) begin
        xl.code = {zc, n_val};
      end else if (has8 && n_cnt == 4'h0) begin
        xl.code = {zc, DIGIT_EIGHT};
      end else if (has8 && n_cnt == 4'h1 && n_val >= 4'h3 &&
                   n_val <= 4'h7) begin
        xl.code = {zc, DIGIT_EIGHT + n_val};
      end else if (has8 && n_cnt == 4'h1 && n_val == 4'h2 &&
                   zc == ZONE_0) begin
        xl.code = {zc, DIGIT_EIGHT + n_val};
      end
    end
  end

endmodule
`default_nettype wire

// *** rtl/card_column_reader.sv ***
// control for an 80-column punched-card reader on the processor i/o bus
//
// How it works
// - translate columns in character mode, else pass
// - six characters or three columns per word
// - character words from six-column groups, fourteen words
// - binary words from three-column groups in order
// - not ready when any reader fault active, validity error only when enabled
// - error flag bit 25 on reader failure
// - end-of-file flag bit 26 from pushbutton
// - end-of-card after column 80 sets done
// - data missed when unread word overwritten
// - every-column flag raises done per column
// - mode bit: zero character, one binary
// - busy bit 31 while card being read
// - done on full word or card end
// - bits 33-35 hold interrupt channel number
// - one conditions-out starts whole 80-column read
// - final binary word holds columns 79, 80
// - conditions-out clears buffer; early one rereads
// - respond only to own device number
// - channel zero means no interrupt line
// - conditions-in returns status, data-in returns data
`timescale 1ns/1ps
`default_nettype none
module card_column_reader
  import card_reader_pkg::*;
#(
  parameter int REREAD_CYC = REREAD_WIN_CYC
) (
  input wire logic clk_sys,
  input wire logic rst_b,
  // ---------------------------------------------------------------
  // processor i/o bus
  // ---------------------------------------------------------------
  input wire logic [6:0] io_dev_num,
  input wire logic conditions_out_cmd,
  input wire logic conditions_in_cmd,
  input wire logic data_in_cmd,
  input wire logic [WORD_W-1:0] io_wdata,
  output logic [WORD_W-1:0] io_rdata,
  output logic [7:1] pi_req,
  // ---------------------------------------------------------------
  // reader mechanism
  // ---------------------------------------------------------------
  input wire logic col_strobe,
  input wire logic [COL_W-1:0] col_data,
  input wire logic rdr_power_off,
  input wire logic rdr_validity_en,
  input wire logic rdr_validity_err,
  input wire logic rdr_jam,
  input wire logic rdr_stacker_full,
  input wire logic rdr_hopper_empty,
  input wire logic rdr_covers_open,
  input wire logic rdr_start_off,
  input wire logic rdr_read_fault,
  input wire logic rdr_fail,
  input wire logic rdr_eof_button,
  output logic rdr_run,
  output logic rdr_reread_first
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    rd_state_t st;
    logic all_col;
    logic mode;
    logic [PIA_W-1:0] pia;
    logic done;
    logic eoc;
    logic missed;
    logic error;
    logic eof;
    logic [6:0] col_cnt;
    logic [2:0] in_word;
    logic [WORD_W-1:0] asm_word;
    logic [WORD_W-1:0] buf_word;
    logic [WORD_W-1:0] rd_data;
    logic reread;
    logic [TIMER_W-1:0] timer;
  } cr_state_t;

  localparam cr_state_t STATE_RESET = '{
    st: ST_IDLE,
    all_col: FLAG_RESET,
    mode: MODE_CHAR,
    pia: PIA_RESET,
    done: FLAG_RESET,
    eoc: FLAG_RESET,
    missed: FLAG_RESET,
    error: FLAG_RESET,
    eof: FLAG_RESET,
    col_cnt: 7'h00,
    in_word: 3'h0,
    asm_word: WORD_RESET,
    buf_word: WORD_RESET,
    rd_data: WORD_RESET,
    reread: FLAG_RESET,
    timer: '0
  };

  localparam logic [TIMER_W-1:0] WIN = TIMER_W'(REREAD_CYC);

  cr_state_t s;
  cr_state_t next_s;

  logic sel;
  logic busy;
  logic not_ready;
  logic [STAT_W-1:0] status;
  logic [WORD_W-1:0] next_asm;
  logic word_full;
  logic last_col;
  logic push;

  col_xlate_if xl ();

  col_translator u_xlate (
    .xl(xl.xlate)
  );

  assign xl.column = col_data;

  // ---------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------
  always_comb begin
    sel = (io_dev_num == DEV_NUM);
    busy = (s.st == ST_READ);
    not_ready = rdr_power_off | (rdr_validity_en & rdr_validity_err) |
                rdr_jam | rdr_stacker_full | rdr_hopper_empty |
                rdr_covers_open | rdr_start_off | rdr_read_fault;
    status = '0;
    status[POS_NOT_READY] = not_ready;
    status[POS_ERROR] = s.error;
    status[POS_EOF] = s.eof;
    status[POS_EOC] = s.eoc;
    status[POS_MISSED] = s.missed;
    status[POS_ALL] = s.all_col;
    status[POS_MODE] = s.mode;
    status[POS_BUSY] = busy;
    status[POS_DONE] = s.done;
    status[POS_PIA +: PIA_W] = s.pia;
  end

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.rd_data = WORD_RESET;
    next_s.reread = 1'b0;
    next_asm = s.asm_word;
    word_full = 1'b0;
    last_col = 1'b0;
    push = 1'b0;
    if (s.timer < WIN) begin
      next_s.timer = s.timer + TIMER_W'(1);
    end

    if (rdr_fail) begin
      next_s.error = 1'b1;
    end
    if (rdr_eof_button) begin
      next_s.eof = 1'b1;
    end

    if (sel && conditions_in_cmd) begin
      next_s.rd_data = {{(WORD_W-STAT_W){1'b0}}, status};
    end
    if (sel && data_in_cmd) begin
      next_s.rd_data = s.buf_word;
      next_s.done = 1'b0;
      next_s.missed = 1'b0;
    end

    // column arrival; a set here wins over a data-in clear
    if (busy && col_strobe) begin
      if (s.mode == MODE_BIN) begin
        next_asm = {s.asm_word[WORD_W-COL_W-1:0], col_data};
        word_full = (s.in_word + 3'h1) == COLS_PER_BIN_WORD;
      end else begin
        next_asm = {s.asm_word[WORD_W-CHAR_W-1:0], xl.code};
        word_full = (s.in_word + 3'h1) == CHARS_PER_WORD;
      end
      next_s.col_cnt = s.col_cnt + 7'h01;
      last_col = next_s.col_cnt == COLS_PER_CARD;
      push = word_full | last_col | s.all_col;
      next_s.in_word = word_full ? 3'h0 : s.in_word + 3'h1;
      next_s.asm_word = (word_full | last_col) ? WORD_RESET : next_asm;
      if (push) begin
        // partial last word stays right-adjusted
        next_s.buf_word = next_asm;
        next_s.done = 1'b1;
        if (s.done && !(sel && data_in_cmd)) begin
          next_s.missed = 1'b1;
        end
      end
      if (last_col) begin
        next_s.eoc = 1'b1;
        next_s.done = 1'b1;
        next_s.st = ST_IDLE;
      end
    end

    // conditions-out reloads control and clears the card state; only an early one while busy rereads from the first column
    if (sel && conditions_out_cmd) begin
      next_s.all_col = io_wdata[POS_ALL];
      next_s.mode = io_wdata[POS_MODE];
      next_s.pia = io_wdata[POS_PIA +: PIA_W];
      next_s.st = io_wdata[POS_BUSY] ? ST_READ : ST_IDLE;
      next_s.done = 1'b0;
      next_s.eoc = 1'b0;
      next_s.missed = 1'b0;
      next_s.error = rdr_fail;
      next_s.eof = rdr_eof_button;
      next_s.col_cnt = 7'h00;
      next_s.in_word = 3'h0;
      next_s.asm_word = WORD_RESET;
      next_s.buf_word = WORD_RESET;
      next_s.reread = busy && (s.timer < WIN);
      next_s.timer = '0;
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      s <= STATE_RESET;
    end else begin
      s <= next_s;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 1; i <= 7; i++) begin
      pi_req[i] = s.done && (s.pia == PIA_W'(i));
    end
  end

  assign io_rdata = s.rd_data;
  assign rdr_run = busy;
  assign rdr_reread_first = s.reread;

endmodule
`default_nettype wire

// *** bench/card_reader_chk.sv ***
// port assertions for the card column reader
`timescale 1ns/1ps
`default_nettype none
module card_reader_chk
  import card_reader_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_b,
  input wire logic [6:0] io_dev_num,
  input wire logic conditions_out_cmd,
  input wire logic conditions_in_cmd,
  input wire logic data_in_cmd,
  input wire logic [WORD_W-1:0] io_wdata,
  input wire logic [WORD_W-1:0] io_rdata,
  input wire logic [7:1] pi_req,
  input wire logic rdr_jam,
  input wire logic rdr_hopper_empty,
  input wire logic rdr_run,
  input wire logic rdr_reread_first
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  logic sel;
  logic stat;
  logic go;
  assign sel = io_dev_num == DEV_NUM;
  assign stat = sel && conditions_in_cmd && !data_in_cmd;
  assign go = sel && conditions_out_cmd;
  property p_quiet;
    io_rdata != '0 |-> $past(sel && (conditions_in_cmd || data_in_cmd));
  endproperty
  a_quiet: assert property (p_quiet) else $error("rdata unasked");
  property p_foreign;
    !sel |=> io_rdata == '0;
  endproperty
  a_foreign: assert property (p_foreign) else $error("foreign answer");
  property p_hi_zero;
    stat |=> io_rdata[35:18] == '0;
  endproperty
  a_hi_zero: assert property (p_hi_zero) else $error("status high");
  property p_one_line;
    $onehot0(pi_req);
  endproperty
  a_one_line: assert property (p_one_line) else $error("two lines");
  property p_start;
    go && io_wdata[4] |=> rdr_run;
  endproperty
  a_start: assert property (p_start) else $error("no start");
  property p_stop;
    go && !io_wdata[4] |=> !rdr_run;
  endproperty
  a_stop: assert property (p_stop) else $error("no stop");
  property p_not_ready;
    stat && (rdr_jam || rdr_hopper_empty) |=> io_rdata[11];
  endproperty
  a_not_ready: assert property (p_not_ready) else $error("ready");
  property p_eoc;
    stat ##1 io_rdata[8] |-> !io_rdata[4] && !rdr_run;
  endproperty
  a_eoc: assert property (p_eoc) else $error("busy at end");
  property p_pulse;
    rdr_reread_first |=> !rdr_reread_first;
  endproperty
  a_pulse: assert property (p_pulse) else $error("long reread");
  property p_reread;
    rdr_reread_first |-> $past(go);
  endproperty
  a_reread: assert property (p_reread) else $error("stray reread");
endmodule
bind card_column_reader card_reader_chk u_chk (.clk_sys, .rst_b,
  .io_dev_num, .conditions_out_cmd, .conditions_in_cmd, .data_in_cmd,
  .io_wdata, .io_rdata, .pi_req, .rdr_jam, .rdr_hopper_empty, .rdr_run,
  .rdr_reread_first);
`default_nettype wire

// *** bench/card_feeder_model.sv ***
// reader mechanism model feeding card columns while the reader runs
`timescale 1ns/1ps
`default_nettype none
module card_feeder_model (
  input wire logic clk_sys,
  input wire logic rdr_run,
  input wire logic rdr_reread_first,
  input wire logic [959:0] deck,
  input wire logic [3:0] gap,
  output logic col_strobe,
  output logic [11:0] col_data
);
  int idx = 0;
  int cnt = 0;
  logic stb = 1'b0;
  logic [11:0] dat = 12'h000;
  assign col_strobe = stb;
  assign col_data = dat;
  always @(negedge clk_sys) begin
    if (!rdr_run || rdr_reread_first) begin
      stb <= 1'b0;
      dat <= ~dat;
      idx <= 0;
      cnt <= 0;
    end else if (idx < 80 && cnt >= int'(gap)) begin
      stb <= 1'b1;
      dat <= deck[idx*12 +: 12];
      idx <= idx + 1;
      cnt <= 0;
    end else begin
      stb <= 1'b0;
      dat <= ~dat;
      cnt <= cnt + 1;
    end
  end
endmodule
`default_nettype wire

// *** bench/card_column_reader_tb_top.sv ***
// self-checking bench for the card column reader
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin \
  n_mismatch++; $display("mismatch %s exp %h got %h", n, e, a); end end
module card_column_reader_tb_top
  import card_reader_pkg::*;
;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic [6:0] io_dev_num = '0;
  logic conditions_out_cmd = 1'b0;
  logic conditions_in_cmd = 1'b0;
  logic data_in_cmd = 1'b0;
  logic [35:0] io_wdata = '0;
  logic [35:0] io_rdata;
  logic [7:1] pi_req;
  logic col_strobe;
  logic [11:0] col_data;
  logic [7:0] flt = '0;
  logic rdr_validity_en = 1'b1;
  logic rdr_fail = 1'b0;
  logic rdr_eof_button = 1'b0;
  logic rdr_run;
  logic rdr_reread_first;
  logic [959:0] deck = '0;
  logic [5:0] code [80];
  logic [3:0] gap = '0;
  logic [31:0] rnd = 32'hA44435A7;
  int n_mismatch = 0;
  int n_checks = 0;
  always #50 clk_sys = ~clk_sys;
  card_column_reader #(.REREAD_CYC(400)) DUT (.clk_sys, .rst_b,
    .io_dev_num, .conditions_out_cmd, .conditions_in_cmd, .data_in_cmd,
    .io_wdata, .io_rdata, .pi_req, .col_strobe, .col_data,
    .rdr_power_off(flt[0]), .rdr_validity_en, .rdr_validity_err(flt[1]),
    .rdr_jam(flt[2]), .rdr_stacker_full(flt[3]), .rdr_hopper_empty(flt[4]),
    .rdr_covers_open(flt[5]), .rdr_start_off(flt[6]),
    .rdr_read_fault(flt[7]), .rdr_fail, .rdr_eof_button, .rdr_run,
    .rdr_reread_first);
  card_feeder_model u_feed (.clk_sys, .rdr_run, .rdr_reread_first, .deck,
    .gap, .col_strobe, .col_data);
  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [35:0] st(input logic [8:0] f,
                                     input logic [2:0] ch);
    return {24'h000000, f, ch};
  endfunction
  task automatic end_of_test;
    if (n_mismatch == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic io(input logic [2:0] k, input logic [6:0] d,
                    input logic [35:0] w, output logic [35:0] r);
    @(negedge clk_sys);
    {conditions_out_cmd, conditions_in_cmd, data_in_cmd} = k;
    io_dev_num = d;
    io_wdata = w;
    @(negedge clk_sys);
    {conditions_out_cmd, conditions_in_cmd, data_in_cmd} = 3'h0;
    r = io_rdata;
  endtask
  task automatic make_deck;
    logic [3:0] d;
    logic [1:0] z;
    for (int i = 0; i < 80; i++) begin
      rnd = lfsr(rnd);
      z = rnd[1:0];
      d = 4'(rnd[5:2] % 9) + 4'h1;
      deck[i*12 +: 12] = rnd[7:6] == 2'h0 ? 12'h000 : ((z != 2'h0 ?
        12'h001 << (8 + z) : 12'h000) | 12'h001 << (9 - d));
      code[i] = rnd[7:6] == 2'h0 ? 6'h10 : {z, d};
    end
  endtask
  task automatic poll(input int b, output logic [35:0] r);
    r = '0;
    for (int t = 0; t < 40 && r[b] !== 1'b1; t++) io(3'h2, DEV_NUM, '0, r);
  endtask
  task automatic card(input logic m, input logic [2:0] ch,
                      input logic [3:0] g);
    logic [35:0] r;
    logic [35:0] e;
    int k;
    int t;
    k = m ? 3 : 6;
    gap = g;
    make_deck;
    io(3'h4, DEV_NUM, {30'h0, m, 2'h2, ch}, r);
    io(3'h2, DEV_NUM, '0, r);
    `CHK("busy", st({6'h00, m, 2'h2}, ch), r)
    for (int c = 0; c < 80; c += k) begin
      e = '0;
      for (int j = c; j < c + k && j < 80; j++)
        e = m ? {e[23:0], deck[j*12 +: 12]} : {e[29:0], code[j]};
      t = 0;
      while (pi_req[ch] !== 1'b1 && t < 300) begin
        @(negedge clk_sys);
        t++;
      end
      `CHK("irq", 7'h01 << (ch - 1), pi_req)
      io(3'h1, DEV_NUM, '0, r);
      `CHK("word", e, r)
      @(negedge clk_sys);
      `CHK("irq drop", 7'h00, pi_req)
    end
    io(3'h2, DEV_NUM, '0, r);
    `CHK("end", st({3'h0, 1'b1, 2'h0, m, 2'h0}, ch), r)
  endtask
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [35:0] r;
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    io(3'h2, DEV_NUM, '0, r);
    `CHK("reset", st(9'h000, 3'h0), r)
    io(3'h6, DEV_NUM ^ 7'h01, 36'h0000000FF, r);
    `CHK("foreign", 37'h0, {rdr_run, r})
    rnd = lfsr(rnd);
    card(MODE_CHAR, 3'(1 + rnd % 7), 4'h1);
    rnd = lfsr(rnd);
    card(MODE_BIN, 3'(1 + rnd % 7), 4'h3);
    make_deck;
    deck[11:0] = deck[11:0] | 12'h005;
    gap = 4'h6;
    io(3'h4, DEV_NUM, 36'h000000070, r);
    poll(3, r);
    `CHK("all", st(9'h00F, 3'h0), r)
    `CHK("no line", 7'h00, pi_req)
    io(3'h1, DEV_NUM, '0, r);
    `CHK("column", {24'h000000, deck[11:0]}, r)
    poll(7, r);
    `CHK("missed", 1'b1, r[7])
    io(3'h4, DEV_NUM, 36'h000000070, r);
    `CHK("reread", 1'b1, rdr_reread_first)
    io(3'h1, DEV_NUM, '0, r);
    `CHK("cleared", 36'h0, r)
    poll(3, r);
    io(3'h1, DEV_NUM, '0, r);
    `CHK("first again", {24'h000000, deck[11:0]}, r)
    io(3'h4, DEV_NUM, '0, r);
    for (int i = 0; i < 8; i++) begin
      flt = 8'h01 << i;
      io(3'h2, DEV_NUM, '0, r);
      `CHK("not ready", 1'b1, r[11])
    end
    rdr_validity_en = 1'b0;
    flt = 8'h02;
    io(3'h2, DEV_NUM, '0, r);
    `CHK("unchecked", 1'b0, r[11])
    flt = 8'h00;
    rdr_fail = 1'b1;
    rdr_eof_button = 1'b1;
    io(3'h2, DEV_NUM, '0, r);
    rdr_fail = 1'b0;
    rdr_eof_button = 1'b0;
    io(3'h2, DEV_NUM, '0, r);
    `CHK("fail eof", 2'h3, r[10:9])
    end_of_test;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    end_of_test;
  end
endmodule
`default_nettype wire
